// ---- lfbt_map.vh ----
/*
 Register layout and timing constants for the LCD frame and boost timing block.
 Assumes a single system clock with low-speed clock ticks supplied as enables.
*/
// Contract
// - Four drive methods chosen by drive-method field.
// - High-speed frame base: divide 2^17,16,15,13.
// - Low-speed frame base: divide 2^9 or 2^8.
// - Frame rate scales 1, 4/3, 2 by duty.
// - Booster enable picks booster or resistor divider.
// - Boost clock from table of high/low dividers.
// - Display off drives all outputs to ground; code zeroes only com_active and display_enable.
// - Stop entry clears display-on bit.
`ifndef LFBT_MAP_VH
`define LFBT_MAP_VH
`define LFBT_ADDR_CTRL 8'h00
`define LFBT_ADDR_STATUS 8'h01
`define LFBT_CTRL_RESET 8'h00
`define LFBT_BIT_DISPLAY_ON 7
`define LFBT_BIT_BOOSTER_EN 6
`define LFBT_BOOST_HI 5
`define LFBT_BOOST_LO 4
`define LFBT_DUTY_HI 3
`define LFBT_DUTY_LO 2
`define LFBT_FRAME_HI 1
`define LFBT_FRAME_LO 0
`define LFBT_DUTY_QUARTER 2'b00
`define LFBT_DUTY_THIRD 2'b01
`define LFBT_DUTY_HALF 2'b10
`define LFBT_DUTY_STATIC 2'b11
`define LFBT_DIV_WIDTH 18
`endif

// ---- lfbt_tick_div.v ----
/*
 Free-running divider that turns a tick enable into power-of-two tap pulses.
 Assumes the tick enable is synchronous to the clock.
*/
`timescale 1ns/1ps
module lfbt_tick_div #(
   parameter WIDTH = 18
) (
   input wire clk_sys,
   input wire resetn,
   input wire tick,
   output reg [WIDTH-1:0] pulse
);
   reg [WIDTH-1:0] count;
   wire [WIDTH-1:0] next_count;
   assign next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
   // Bit k pulses once every 2^(k+1) ticks, when bits k..0 roll to zero.
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         count <= {WIDTH{1'b0}};
         pulse <= {WIDTH{1'b0}};
      end else begin
         if (tick) begin
            count <= next_count;
            pulse <= count & ~next_count;
         end else begin
            pulse <= {WIDTH{1'b0}};
         end
      end
   end
endmodule // lfbt_tick_div

// ---- lfbt_timing.v ----
/*
 LCD frame and booster timing: control register, frame base and boost clock
 selection, common slot sequencing and blanking.
 Assumes hs_tick and ls_tick are one-cycle enables at the high-speed and
 low-speed clock rates, synchronous to clk_sys; stop_entry is a same-clock pulse.
*/
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "lfbt_map.vh"
module lfbt_timing (
   input wire clk_sys,
   input wire resetn,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   input wire hs_tick,
   input wire ls_tick,
   input wire timer_clock_source_sel,
   input wire system_clock_sel,
   input wire stop_entry,
   output reg [3:0] com_active,
   output reg slot_pulse,
   output reg frame_pulse,
   output reg boost_clk_pulse,
   output reg booster_on,
   output reg divider_on,
   output reg display_enable
);
   reg [7:0] lcd_control_reg;
   reg [1:0] slot;
   reg [1:0] sub;
   wire [`LFBT_DIV_WIDTH-1:0] hs_pulse;
   wire [`LFBT_DIV_WIDTH-1:0] ls_pulse;
   wire display_on = lcd_control_reg[`LFBT_BIT_DISPLAY_ON];
   wire booster_enable = lcd_control_reg[`LFBT_BIT_BOOSTER_EN];
   wire [1:0] boost_freq_sel = lcd_control_reg[`LFBT_BOOST_HI:`LFBT_BOOST_LO];
   wire [1:0] duty = lcd_control_reg[`LFBT_DUTY_HI:`LFBT_DUTY_LO];
   wire [1:0] frame_base_sel = lcd_control_reg[`LFBT_FRAME_HI:`LFBT_FRAME_LO];
   wire low_src = timer_clock_source_sel | system_clock_sel;

   lfbt_tick_div #(.WIDTH(`LFBT_DIV_WIDTH)) u_hs (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .tick(hs_tick),
      .pulse(hs_pulse)
   );
   lfbt_tick_div #(.WIDTH(`LFBT_DIV_WIDTH)) u_ls (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .tick(ls_tick),
      .pulse(ls_pulse)
   );

   // Divide by 2^n is tap n-1 of the divider.
   function tap;
      input [`LFBT_DIV_WIDTH-1:0] p;
      input integer n;
      begin
         tap = p[n-1];
      end
   endfunction

   // Index of the last common slot per frame for a drive method.
   function [1:0] last_slot;
      input [1:0] d;
      begin
         case (d)
            `LFBT_DUTY_QUARTER: last_slot = 2'd3;
            `LFBT_DUTY_THIRD: last_slot = 2'd2;
            `LFBT_DUTY_HALF: last_slot = 2'd1;
            default: last_slot = 2'd0;
         endcase
      end
   endfunction

   reg base_pulse;
   always @* begin
      if (low_src) begin
         case (frame_base_sel)
            2'b00: base_pulse = tap(ls_pulse, 9);
            2'b01: base_pulse = tap(ls_pulse, 8);
            2'b10: base_pulse = tap(hs_pulse, 15);
            default: base_pulse = tap(hs_pulse, 13);
         endcase
      end else begin
         case (frame_base_sel)
            2'b00: base_pulse = tap(hs_pulse, 17);
            2'b01: base_pulse = tap(hs_pulse, 16);
            2'b10: base_pulse = tap(hs_pulse, 15);
            default: base_pulse = tap(hs_pulse, 13);
         endcase
      end
   end

   reg boost_pulse;
   always @* begin
      case (boost_freq_sel)
         2'b00: boost_pulse = low_src ? tap(ls_pulse, 5) : tap(hs_pulse, 13);
         2'b01: boost_pulse = low_src ? tap(ls_pulse, 3) : tap(hs_pulse, 11);
         2'b10: boost_pulse = low_src ? tap(ls_pulse, 2) : tap(hs_pulse, 10);
         default: boost_pulse = tap(hs_pulse, 9);
      endcase
   end

   // The base period holds four slot ticks; a frame uses duty-count of them,
   // so the frame runs at base, 4/3 base or 2x base.
   wire quarter_tick = low_src ? ls_pulse[0] : hs_pulse[0];
   reg quarter_gate;
   always @* begin
      case (frame_base_sel)
         2'b00: quarter_gate = low_src ? tap(ls_pulse, 7) : tap(hs_pulse, 15);
         2'b01: quarter_gate = low_src ? tap(ls_pulse, 6) : tap(hs_pulse, 14);
         2'b10: quarter_gate = tap(hs_pulse, 13);
         default: quarter_gate = tap(hs_pulse, 11);
      endcase
   end
   wire slot_tick = quarter_gate & quarter_tick;

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         lcd_control_reg <= `LFBT_CTRL_RESET;
         rdata <= 8'h00;
         slot <= 2'd0;
         sub <= 2'd0;
         com_active <= 4'h0;
         slot_pulse <= 1'b0;
         frame_pulse <= 1'b0;
         boost_clk_pulse <= 1'b0;
         booster_on <= 1'b0;
         divider_on <= 1'b0;
         display_enable <= 1'b0;
      end else begin
         if (wr && addr == `LFBT_ADDR_CTRL) begin
            lcd_control_reg <= wdata;
         end
         if (stop_entry) begin
            lcd_control_reg[`LFBT_BIT_DISPLAY_ON] <= 1'b0;
         end
         rdata <= 8'h00;
         if (rd) begin
            case (addr)
               `LFBT_ADDR_CTRL: rdata <= lcd_control_reg;
               `LFBT_ADDR_STATUS: rdata <= {2'b00, sub, com_active};
               default: rdata <= 8'h00;
            endcase
         end
         slot_pulse <= 1'b0;
         frame_pulse <= 1'b0;
         if (slot_tick) begin
            slot_pulse <= 1'b1;
            if (slot >= last_slot(duty)) begin
               slot <= 2'd0;
               // Static drive has one slot, yet its frame spans the whole base period.
               if (duty != `LFBT_DUTY_STATIC || sub == 2'd3) begin
                  frame_pulse <= 1'b1;
               end
            end else begin
               slot <= slot + 2'd1;
            end
            sub <= sub + 2'd1;
         end
         com_active <= display_on ? (4'h1 << slot) : 4'h0;
         display_enable <= display_on;
         boost_clk_pulse <= booster_enable & boost_pulse;
         booster_on <= booster_enable;
         divider_on <= ~booster_enable;
      end
   end
endmodule // lfbt_timing

// ---- lfbt_panel.sv ----
/* Panel stand-in counting frames that light common 0.
   Assumes commons are one-hot and zero while blanked. */
`timescale 1ns/1ps
module lfbt_panel (
   input wire clk_sys,
   input wire [3:0] com_active,
   output reg [15:0] frames_lit
);
   reg lit0 = 1'b0;
   initial frames_lit = 16'h0000;
   always @(posedge clk_sys) begin
      lit0 <= com_active[0];
      if (com_active[0] && !lit0) frames_lit <= frames_lit + 16'h0001;
   end
endmodule // lfbt_panel

// ---- lfbt_timing_monitor.sv ----
/* Port assertions for the LCD timing block.
   Assumes the bind below and one clock. */
`timescale 1ns/1ps
module lfbt_monitor (
   input wire clk_sys,
   input wire resetn,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   input wire [7:0] rdata,
   input wire stop_entry,
   input wire [3:0] com_active,
   input wire slot_pulse,
   input wire boost_clk_pulse,
   input wire booster_on,
   input wire divider_on,
   input wire display_enable
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   property p_blank; !display_enable |-> com_active == 4'h0; endproperty
   a_blank: assert property (p_blank) else $error("lit while blank");
   property p_one; $onehot0(com_active); endproperty
   a_one: assert property (p_one) else $error("two commons");
   property p_slot; slot_pulse |=> !slot_pulse; endproperty
   a_slot: assert property (p_slot) else $error("long slot");
   property p_src; booster_on |-> !divider_on; endproperty
   a_src: assert property (p_src) else $error("two sources");
   property p_bclk; boost_clk_pulse |-> booster_on; endproperty
   a_bclk: assert property (p_bclk) else $error("boost while off");
   property p_stop; stop_entry |-> ##2 !display_enable; endproperty
   a_stop: assert property (p_stop) else $error("stop kept display");
   property p_rd; !rd |=> rdata == 8'h00; endproperty
   a_rd: assert property (p_rd) else $error("stray read data");
   property p_wr; wr && addr == 8'h00 && !stop_entry |-> ##2
      display_enable == $past(wdata[7], 2) && booster_on == $past(wdata[6], 2); endproperty
   a_wr: assert property (p_wr) else $error("write not applied");
endmodule // lfbt_monitor
bind lfbt_timing lfbt_monitor mon (.clk_sys(clk_sys), .resetn(resetn), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .stop_entry(stop_entry),
   .com_active(com_active), .slot_pulse(slot_pulse), .boost_clk_pulse(boost_clk_pulse),
   .booster_on(booster_on), .divider_on(divider_on), .display_enable(display_enable));

// ---- tb_lfbt_timing.sv ----
/* Bench for the LCD timing block.
   Assumes both tick enables held high. */
`timescale 1ns/1ps
module tb_lfbt_timing;
   reg clk_sys = 0, resetn = 0, wr = 0, rd = 0, tcs = 1, scs = 0, stop_entry = 0;
   reg [7:0] addr = 8'h00, wdata = 8'h00;
   wire [7:0] rdata;
   wire [3:0] com;
   wire [2:0] pul;
   wire bon, don, den;
   wire [15:0] lit;
   integer fails = 0, n_tests = 0, d, k0;
   always #20 clk_sys = ~clk_sys;
   lfbt_timing dut (.clk_sys(clk_sys), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .hs_tick(1'b1), .ls_tick(1'b1), .timer_clock_source_sel(tcs),
      .system_clock_sel(scs), .stop_entry(stop_entry), .com_active(com), .slot_pulse(pul[0]),
      .frame_pulse(pul[1]), .boost_clk_pulse(pul[2]), .booster_on(bon), .divider_on(don),
      .display_enable(den));
   lfbt_panel panel (.clk_sys(clk_sys), .com_active(com), .frames_lit(lit));
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task finish_test;
      begin
         $display("%0d compares, %0d mismatches", n_tests, fails);
         if (fails == 0 && n_tests > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   task acc(input w, input [7:0] a, input [7:0] v);
      begin
         @(posedge clk_sys);
         addr <= a;
         wdata <= v;
         wr <= w;
         rd <= !w;
         @(posedge clk_sys);
         wr <= 1'b0;
         rd <= 1'b0;
         @(negedge clk_sys);
         if (!w) chk(rdata, v);
      end
   endtask
   // Measures the spacing of the second and third pulses, skipping stale ones.
   task per(input integer s, input integer e);
      integer n, k;
      begin
         n = 0;
         k = 0;
         while (k < 3 && n < 9000) begin
            @(negedge clk_sys);
            n = n + 1;
            if (pul[s] === 1'b1) begin
               k = k + 1;
               if (k < 3) n = 0;
            end
         end
         chk(n, e);
         if (k < 3) finish_test;
      end
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      acc(0, 8'h00, 8'h00);
      acc(0, 8'h05, 8'h00);
      acc(1, 8'h00, 8'h61);
      repeat (2) @(negedge clk_sys);
      chk({bon, don, den, com}, 7'h40);
      per(2, 4);
      $display("booster test done");
      for (d = 0; d < 4; d = d + 1) begin
         acc(1, 8'h00, {4'h8, d[1:0], 2'b01});
         acc(0, 8'h00, {4'h8, d[1:0], 2'b01});
         per(0, 64);
         per(1, (d == 3) ? 256 : 256 - 64 * d);
      end
      @(posedge clk_sys);
      tcs <= 1'b0;
      acc(1, 8'h00, 8'h83);
      per(1, 8192);
      @(posedge clk_sys);
      scs <= 1'b1;
      acc(1, 8'h00, 8'h80);
      per(1, 512);
      $display("frame test done");
      chk(lit > 16'h0000, 32'h1);
      @(posedge clk_sys);
      stop_entry <= 1'b1;
      @(posedge clk_sys);
      stop_entry <= 1'b0;
      repeat (3) @(negedge clk_sys);
      k0 = lit;
      repeat (600) @(negedge clk_sys);
      chk({den, lit - k0[15:0]}, 17'h0);
      acc(0, 8'h00, 8'h00);
      @(posedge clk_sys);
      scs <= 1'b0;
      acc(1, 8'h00, 8'h70);
      per(2, 512);
      $display("stop and boost test done");
      finish_test;
   end
endmodule // tb_lfbt_timing
